// ---- serial_control_port.sv ----
/*
 * serial control port: spi-style or i2c slave giving a host access to the
 * register map. holds config registers 0x00, 0x01 and the transfer strobe at
 * 0x0f; all other writes leave on wr_req, reads come back on rd_data.
 * assumes the outside register map answers rd_data combinationally from
 * rd_addr and copies buffer to active registers on xfer_pulse.
 */
`timescale 1ns/1ns
`default_nettype none

// How it works
// - 16 instruction bits first, rising edges
// - top bit direction, then 15 address bits
// - topmost address bit forced to zero
// - write bits sampled on rising clock edge
// - writes other than 0x00, 0x01, 0x0f wait in buffers until transfer
// - 0x0f bit0 fires transfer, self clears
// - external pin can also fire transfer
// - transfer copies all buffers to active
// - read bytes driven on falling edges
// - readback never skips any address
// - 0x01 bit5 picks buffer or active readback
// - 0x00 bit6 selects lsb first, next operation
// - 0x00 bit5 chooses increment or decrement
// - streaming spans 0x0000 to 0x3a3b contiguously
// - i2c works at 100 and 400 khz
// - i2c slave only, never drives scl
// - i2c register address is 16 bits
// - answer only own selectable 7-bit address
// - start and stop seen with scl high
// - i2c bytes msb first, ninth bit ack
// - nack on ninth bit returns to idle
// - chip select bounds a transfer, any length
// - data pins high impedance while deselected
// - three wire shares pin, four wire separates
// - protocol chosen at start-up by strap
module serial_control_port #(
   parameter logic [4:0] I2C_ADDR_BASE = 5'h12
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic protocol_select_pin,
   input wire logic [1:0] i2c_addr_sel,
   input wire logic chip_select_n,
   input wire logic spi_clk,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic xfer_pin,
   input wire logic xfer_pin_en,
   output logic wr_valid,
   output serial_control_port_pkg::wr_req_t wr_req,
   output logic [serial_control_port_pkg::ADDR_W-1:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic rd_from_active,
   output logic xfer_pulse,
   output logic i2c_mode
);

   localparam int AW = serial_control_port_pkg::ADDR_W;

   // =====================================================================
   // pin synchronisers (no reset: data only)
   logic [1:0] cs_m, sck_m, sdi_m, scl_m, sda_m, xp_m, ps_m;
   logic [3:0] as_m;
   logic cs_s, sck_s, sck_p, sdi_s, scl_s, scl_p, sda_s, sda_p, xp_s, xp_p;

   // two flops per pin, then one more stage on sck, scl, sda and xfer_pin for edge detection
   always_ff @(posedge ref_clk) begin
      cs_m <= {cs_m[0], chip_select_n};
      sck_m <= {sck_m[0], spi_clk};
      sdi_m <= {sdi_m[0], sdio_i};
      scl_m <= {scl_m[0], scl_i};
      sda_m <= {sda_m[0], sda_i};
      xp_m <= {xp_m[0], xfer_pin};
      ps_m <= {ps_m[0], protocol_select_pin};
      as_m <= {as_m[1:0], i2c_addr_sel};
      sck_p <= sck_m[1];
      scl_p <= scl_m[1];
      sda_p <= sda_m[1];
      xp_p <= xp_m[1];
   end
   assign cs_s = cs_m[1];
   assign sck_s = sck_m[1];
   assign sdi_s = sdi_m[1];
   assign scl_s = scl_m[1];
   assign sda_s = sda_m[1];
   assign xp_s = xp_m[1];

   // =====================================================================
   // shared state: straps, config registers, write port, transfer strobe
   logic init_q, init_d, i2c_q, i2c_d;
   logic [1:0] asel_q, asel_d;
   logic [7:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d;
   logic wrv_q, wrv_d, xfer_q, xfer_d;
   serial_control_port_pkg::wr_req_t wr_q, wr_d;
   logic spi_wr, i2c_wr;
   serial_control_port_pkg::wr_req_t spi_req, i2c_req, req;
   logic lsb_first, ascend, four_wire;
   logic [AW-1:0] spi_addr_q, i2c_addr_q;

   assign lsb_first = cfg0_q[serial_control_port_pkg::LSB_FIRST_POS];
   assign ascend = cfg0_q[serial_control_port_pkg::ASCEND_POS];
   assign four_wire = cfg0_q[serial_control_port_pkg::FOUR_WIRE_POS];

   // next address in a stream, parked at either end of the map
   function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input logic up);
      logic [AW-1:0] n;
      n = a;
      if (up) begin
         if (a != serial_control_port_pkg::ADDR_MAX) n = a + 14'h0001;
      end else begin
         if (a != serial_control_port_pkg::ADDR_MIN) n = a - 14'h0001;
      end
      return n;
   endfunction

   // read value for an address; blank addresses still answer
   function automatic logic [7:0] rdval(input logic [AW-1:0] a, input logic [7:0] ext);
      logic [7:0] v;
      v = ext;
      if (a == serial_control_port_pkg::CFG0_ADDR) v = cfg0_q;
      if (a == serial_control_port_pkg::CFG1_ADDR) v = cfg1_q;
      if (a == serial_control_port_pkg::XFER_ADDR) v = 8'h00;
      return v;
   endfunction

   // strap capture, config writes and buffer write forwarding
   always_comb begin
      init_d = 1'b1;
      i2c_d = i2c_q;
      asel_d = asel_q;
      if (!init_q) begin
         i2c_d = ps_m[1];
         asel_d = as_m[3:2];
      end
      cfg0_d = cfg0_q;
      cfg1_d = cfg1_q;
      wrv_d = 1'b0;
      wr_d = wr_q;
      xfer_d = xfer_pin_en && xp_s && !xp_p;
      req = i2c_q ? i2c_req : spi_req;
      if (i2c_q ? i2c_wr : spi_wr) begin
         if (req.addr == serial_control_port_pkg::CFG0_ADDR) begin
            cfg0_d = req.data;
         end else if (req.addr == serial_control_port_pkg::CFG1_ADDR) begin
            cfg1_d = req.data;
         end else if (req.addr == serial_control_port_pkg::XFER_ADDR) begin
            if (req.data[serial_control_port_pkg::XFER_POS]) xfer_d = 1'b1;
         end else begin
            wrv_d = 1'b1;
            wr_d = req;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         init_q <= 1'b0;
         i2c_q <= 1'b0;
         asel_q <= 2'h0;
         cfg0_q <= serial_control_port_pkg::CFG0_RST;
         cfg1_q <= serial_control_port_pkg::CFG1_RST;
         wrv_q <= 1'b0;
         wr_q <= '0;
         xfer_q <= 1'b0;
      end else begin
         init_q <= init_d;
         i2c_q <= i2c_d;
         asel_q <= asel_d;
         cfg0_q <= cfg0_d;
         cfg1_q <= cfg1_d;
         wrv_q <= wrv_d;
         wr_q <= wr_d;
         xfer_q <= xfer_d;
      end
   end

   assign wr_valid = wrv_q;
   assign wr_req = wr_q;
   assign xfer_pulse = xfer_q;
   assign rd_from_active = cfg1_q[serial_control_port_pkg::RB_ACTIVE_POS];
   assign i2c_mode = i2c_q;
   assign rd_addr = i2c_q ? i2c_addr_q : spi_addr_q;

   // =====================================================================
   // spi front end
   serial_control_port_pkg::spi_state_t spi_q, spi_d;
   logic [15:0] ssr_q, ssr_d;
   logic [7:0] stx_q, stx_d;
   logic [3:0] scnt_q, scnt_d;
   logic [AW-1:0] spi_addr_d;
   logic slsb_q, slsb_d, sload_q, sload_d, sout_q, sout_d;
   logic sck_rise, sck_fall;

   assign sck_rise = sck_s && !sck_p;
   assign sck_fall = !sck_s && sck_p;

   // instruction, write payload and read payload sequencing
   always_comb begin
      spi_d = spi_q;
      ssr_d = ssr_q;
      stx_d = stx_q;
      scnt_d = scnt_q;
      spi_addr_d = spi_addr_q;
      slsb_d = slsb_q;
      sload_d = 1'b0;
      sout_d = sout_q;
      spi_wr = 1'b0;
      spi_req = '{addr: spi_addr_q, data: ssr_q[7:0]};
      if (cs_s) begin
         spi_d = serial_control_port_pkg::SPI_IDLE;
      end else begin
         case (spi_q)
            serial_control_port_pkg::SPI_IDLE: begin
               spi_d = serial_control_port_pkg::SPI_INSTR;
               scnt_d = 4'h0;
               slsb_d = lsb_first;
            end
            serial_control_port_pkg::SPI_INSTR: begin
               if (sck_rise) begin
                  ssr_d = slsb_q ? {sdi_s, ssr_q[15:1]} : {ssr_q[14:0], sdi_s};
                  scnt_d = scnt_q + 4'h1;
                  if (scnt_q == 4'hf) begin
                     spi_addr_d = ssr_d[AW-1:0];
                     scnt_d = 4'h0;
                     if (ssr_d[serial_control_port_pkg::RW_POS]) begin
                        spi_d = serial_control_port_pkg::SPI_RDATA;
                        sload_d = 1'b1;
                     end else begin
                        spi_d = serial_control_port_pkg::SPI_WDATA;
                     end
                  end
               end
            end
            serial_control_port_pkg::SPI_WDATA: begin
               if (sck_rise) begin
                  ssr_d[7:0] = slsb_q ? {sdi_s, ssr_q[7:1]} : {ssr_q[6:0], sdi_s};
                  scnt_d = scnt_q + 4'h1;
                  if (scnt_q == 4'h7) begin
                     scnt_d = 4'h0;
                     spi_wr = 1'b1;
                     spi_req = '{addr: spi_addr_q, data: ssr_d[7:0]};
                     spi_addr_d = step(spi_addr_q, ascend);
                  end
               end
            end
            serial_control_port_pkg::SPI_RDATA: begin
               if (sload_q) stx_d = rdval(spi_addr_q, rd_data);
               if (sck_fall) begin
                  sout_d = slsb_q ? stx_q[0] : stx_q[7];
                  stx_d = slsb_q ? {1'b0, stx_q[7:1]} : {stx_q[6:0], 1'b0};
               end
               if (sck_rise) begin
                  scnt_d = scnt_q + 4'h1;
                  if (scnt_q == 4'h7) begin
                     scnt_d = 4'h0;
                     spi_addr_d = step(spi_addr_q, ascend);
                     sload_d = 1'b1;
                  end
               end
            end
            default: spi_d = serial_control_port_pkg::SPI_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n || i2c_q) begin
         spi_q <= serial_control_port_pkg::SPI_IDLE;
         ssr_q <= 16'h0000;
         stx_q <= 8'h00;
         scnt_q <= 4'h0;
         spi_addr_q <= '0;
         slsb_q <= 1'b0;
         sload_q <= 1'b0;
         sout_q <= 1'b0;
      end else begin
         spi_q <= spi_d;
         ssr_q <= ssr_d;
         stx_q <= stx_d;
         scnt_q <= scnt_d;
         spi_addr_q <= spi_addr_d;
         slsb_q <= slsb_d;
         sload_q <= sload_d;
         sout_q <= sout_d;
      end
   end

   // drive only during read payload; released whenever chip select is high
   assign sdio_o = sout_q;
   assign serial_data_out = sout_q;
   assign sdio_oe = !cs_s && (spi_q == serial_control_port_pkg::SPI_RDATA) && !four_wire;
   assign serial_data_out_oe = !cs_s && (spi_q == serial_control_port_pkg::SPI_RDATA) && four_wire;

   // =====================================================================
   // i2c front end (scl is input only)
   serial_control_port_pkg::i2c_state_t i2c_st_q, i2c_st_d;
   logic [7:0] isr_q, isr_d, itx_q, itx_d, ihi_q, ihi_d;
   logic [3:0] icnt_q, icnt_d;
   logic [1:0] idx_q, idx_d;
   logic [AW-1:0] i2c_addr_d;
   logic irw_q, irw_d, drv_q, drv_d, iload;
   logic scl_rise, scl_fall, i_start, i_stop;

   assign scl_rise = scl_s && !scl_p;
   assign scl_fall = !scl_s && scl_p;
   assign i_start = scl_s && scl_p && sda_p && !sda_s;
   assign i_stop = scl_s && scl_p && !sda_p && sda_s;

   // byte reception, acknowledge, transmission and master acknowledge
   always_comb begin
      i2c_st_d = i2c_st_q;
      isr_d = isr_q;
      itx_d = itx_q;
      ihi_d = ihi_q;
      icnt_d = icnt_q;
      idx_d = idx_q;
      i2c_addr_d = i2c_addr_q;
      irw_d = irw_q;
      drv_d = drv_q;
      iload = 1'b0;
      i2c_wr = 1'b0;
      i2c_req = '{addr: i2c_addr_q, data: isr_q};
      if (i_start) begin
         i2c_st_d = serial_control_port_pkg::I2C_RX; // partial bytes dropped
         idx_d = 2'h0;
         icnt_d = 4'h0;
         drv_d = 1'b0;
      end else if (i_stop) begin
         i2c_st_d = serial_control_port_pkg::I2C_IDLE;
         drv_d = 1'b0;
      end else begin
         case (i2c_st_q)
            serial_control_port_pkg::I2C_IDLE: drv_d = 1'b0;
            serial_control_port_pkg::I2C_RX: begin
               if (scl_rise) begin
                  isr_d = {isr_q[6:0], sda_s};
                  icnt_d = icnt_q + 4'h1;
               end
               if (scl_fall && icnt_q == 4'h8) begin
                  icnt_d = 4'h0;
                  i2c_st_d = serial_control_port_pkg::I2C_SACK;
                  drv_d = 1'b1;
                  idx_d = (idx_q == 2'h3) ? 2'h3 : idx_q + 2'h1;
                  case (idx_q)
                     2'h0: begin
                        irw_d = isr_q[0];
                        if (isr_q[7:1] != {I2C_ADDR_BASE, asel_q}) begin
                           i2c_st_d = serial_control_port_pkg::I2C_IDLE;
                           drv_d = 1'b0;
                        end
                     end
                     2'h1: ihi_d = isr_q;
                     2'h2: i2c_addr_d = {ihi_q[AW-9:0], isr_q};
                     default: begin
                        i2c_wr = 1'b1;
                        i2c_addr_d = step(i2c_addr_q, ascend);
                     end
                  endcase
               end
            end
            serial_control_port_pkg::I2C_SACK: begin
               if (scl_fall) begin
                  drv_d = 1'b0;
                  i2c_st_d = serial_control_port_pkg::I2C_RX;
                  if (irw_q) iload = 1'b1;
               end
            end
            serial_control_port_pkg::I2C_TX: begin
               if (scl_fall) begin
                  if (icnt_q == 4'h8) begin
                     drv_d = 1'b0;
                     i2c_st_d = serial_control_port_pkg::I2C_MACK;
                  end else begin
                     drv_d = !itx_q[7];
                     itx_d = {itx_q[6:0], 1'b0};
                     icnt_d = icnt_q + 4'h1;
                  end
               end
            end
            serial_control_port_pkg::I2C_MACK: begin
               if (scl_rise && sda_s) i2c_st_d = serial_control_port_pkg::I2C_IDLE;
               else if (scl_fall) iload = 1'b1;
            end
            default: i2c_st_d = serial_control_port_pkg::I2C_IDLE;
         endcase
         if (iload) begin
            itx_d = rdval(i2c_addr_q, rd_data);
            drv_d = !itx_d[7];
            itx_d = {itx_d[6:0], 1'b0};
            icnt_d = 4'h1;
            i2c_addr_d = step(i2c_addr_q, ascend);
            i2c_st_d = serial_control_port_pkg::I2C_TX;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n || !i2c_q) begin
         i2c_st_q <= serial_control_port_pkg::I2C_IDLE;
         isr_q <= 8'h00;
         itx_q <= 8'h00;
         ihi_q <= 8'h00;
         icnt_q <= 4'h0;
         idx_q <= 2'h0;
         i2c_addr_q <= '0;
         irw_q <= 1'b0;
         drv_q <= 1'b0;
      end else begin
         i2c_st_q <= i2c_st_d;
         isr_q <= isr_d;
         itx_q <= itx_d;
         ihi_q <= ihi_d;
         icnt_q <= icnt_d;
         idx_q <= idx_d;
         i2c_addr_q <= i2c_addr_d;
         irw_q <= irw_d;
         drv_q <= drv_d;
      end
   end

   // open drain: only ever pull low; 400 khz leaves ~12 clocks per scl phase
   assign sda_o = 1'b0;
   assign sda_oe = drv_q;

endmodule

`default_nettype wire

// ---- serial_control_port_pkg.sv ----
/*
 * shared constants and carrier types for the serial control port.
 * assumes a single 10 MHz system clock; the register map itself lives outside.
 */
`default_nettype none

package serial_control_port_pkg;

   // =====================================================================
   // geometry
   localparam int ADDR_W = 14;
   localparam int INSTR_BITS = 16;
   localparam int BYTE_BITS = 8;
   localparam int RW_POS = 15;
   localparam logic [ADDR_W-1:0] ADDR_MIN = 14'h0000;
   localparam logic [ADDR_W-1:0] ADDR_MAX = 14'h3a3b;

   // =====================================================================
   // internally held configuration registers
   localparam logic [ADDR_W-1:0] CFG0_ADDR = 14'h0000;
   localparam logic [ADDR_W-1:0] CFG1_ADDR = 14'h0001;
   localparam logic [ADDR_W-1:0] XFER_ADDR = 14'h000f;
   localparam int LSB_FIRST_POS = 6;
   localparam int ASCEND_POS = 5;
   localparam int FOUR_WIRE_POS = 4;
   localparam int RB_ACTIVE_POS = 5;
   localparam int XFER_POS = 0;
   localparam logic [7:0] CFG0_RST = 8'h00;
   localparam logic [7:0] CFG1_RST = 8'h00;

   // =====================================================================
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int I2C_FAST_HZ = 400_000;
   localparam int I2C_STD_HZ = 100_000;
   localparam int I2C_FAST_CYCLES = CLK_HZ / I2C_FAST_HZ;

   // =====================================================================
   // carrier for one register write towards the buffer registers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } wr_req_t;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_INSTR = 2'b01,
      SPI_WDATA = 2'b11,
      SPI_RDATA = 2'b10
   } spi_state_t;

   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_RX = 3'b001,
      I2C_SACK = 3'b011,
      I2C_TX = 3'b010,
      I2C_MACK = 3'b110
   } i2c_state_t;

endpackage

`default_nettype wire

// ---- serial_control_port_sva.sv ----
/*
 checker for the serial control port: pin, pulse and mode relations.
 assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none

// ======================================================================
// checker
module serial_control_port_sva #(
   parameter logic [4:0] I2C_ADDR_BASE = 5'h12
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic chip_select_n,
   input wire logic sdio_oe,
   input wire logic serial_data_out_oe,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic wr_valid,
   input wire serial_control_port_pkg::wr_req_t wr_req,
   input wire logic [serial_control_port_pkg::ADDR_W-1:0] rd_addr,
   input wire logic xfer_pulse,
   input wire logic i2c_mode
);
   // one clock domain, reset disables every check
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_desel_hiz: assert property (chip_select_n [*4] |-> !sdio_oe && !serial_data_out_oe)
      else $error("data pin driven while deselected");
   a_pins_apart: assert property (!(sdio_oe && serial_data_out_oe))
      else $error("both spi data pins driven");
   a_i2c_spi_quiet: assert property (i2c_mode |-> !sdio_oe && !serial_data_out_oe)
      else $error("spi pins driven in i2c mode");
   a_mode_held: assert property ($past(reset_n, 2) |-> $stable(i2c_mode))
      else $error("protocol changed without reset");
   a_xfer_once: assert property (xfer_pulse |=> !xfer_pulse)
      else $error("transfer pulse longer than one cycle");
   a_wr_once: assert property (wr_valid |=> !wr_valid)
      else $error("write pulse longer than one cycle");
   a_wr_absorbed: assert property (wr_valid |-> wr_req.addr != serial_control_port_pkg::XFER_ADDR)
      else $error("transfer strobe leaked as buffer write");
   a_addr_range: assert property (rd_addr <= serial_control_port_pkg::ADDR_MAX
      && wr_req.addr <= serial_control_port_pkg::ADDR_MAX)
      else $error("address outside streaming range");
   a_sda_od: assert property (sda_oe |-> !sda_o && i2c_mode)
      else $error("sda driven high or outside i2c mode");
   a_ack_steady: assert property (scl_i [*4] |-> $stable(sda_oe))
      else $error("sda changed while scl high");
endmodule

bind serial_control_port serial_control_port_sva #(.I2C_ADDR_BASE(I2C_ADDR_BASE)) u_sva (.ref_clk, .reset_n,
   .chip_select_n, .sdio_oe, .serial_data_out_oe, .scl_i, .sda_o, .sda_oe, .wr_valid, .wr_req, .rd_addr,
   .xfer_pulse, .i2c_mode);

`default_nettype wire

// ---- regmap_model.sv ----
/*
 behavioural register map beside the port: buffer and active copies of
 the low 64 addresses, zeros above. assumes one write pulse per byte.
*/
`timescale 1ns/1ns
`default_nettype none

// ======================================================================
// register map model
module regmap_model (
   input wire logic ref_clk,
   input wire logic wr_valid,
   input wire serial_control_port_pkg::wr_req_t wr_req,
   input wire logic [serial_control_port_pkg::ADDR_W-1:0] rd_addr,
   input wire logic rd_from_active,
   input wire logic xfer_pulse,
   output logic [7:0] rd_data
);
   logic [7:0] bf_q [64] = '{default: 8'h00};
   logic [7:0] act_q [64] = '{default: 8'h00};

   // writes land in buffers, the strobe copies them all
   always @(posedge ref_clk) begin
      if (xfer_pulse) act_q <= bf_q;
      if (wr_valid && wr_req.addr < 14'h0040) bf_q[wr_req.addr[5:0]] <= wr_req.data;
   end

   // every address answers, unmapped ones read zero
   assign rd_data = (rd_addr >= 14'h0040) ? 8'h00 :
      rd_from_active ? act_q[rd_addr[5:0]] : bf_q[rd_addr[5:0]];
endmodule

`default_nettype wire

// ---- testbench.sv ----
/*
 self-checking bench: spi host tasks, then an i2c master after a reset.
 assumes the checker is bound in and the map model answers reads.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

// ======================================================================
// top
module testbench;
   logic ref_clk, reset_n, protocol_select_pin, chip_select_n, spi_clk, sdio_h, sdio_i, scl, sda_h;
   logic xfer_pin, xfer_pin_en, sdio_o, sdio_oe, serial_data_out, serial_data_out_oe, sda_o, sda_oe;
   logic wr_valid, rd_from_active, xfer_pulse, i2c_mode, sda_line, lsb, four_w, ack;
   logic [1:0] i2c_addr_sel;
   logic [7:0] rd_data, got;
   logic [13:0] rd_addr;
   logic [15:0] r16;
   serial_control_port_pkg::wr_req_t wr_req;
   serial_control_port_pkg::wr_req_t wq[$];
   int miscompares, total_checks, nx, ih;

   // shared pins resolve from all drivers, sda pulled up
   assign sdio_i = sdio_oe ? sdio_o : sdio_h;
   assign sda_line = sda_oe ? sda_o : sda_h;

   serial_control_port u_dut (.ref_clk, .reset_n, .protocol_select_pin, .i2c_addr_sel, .chip_select_n,
      .spi_clk, .sdio_i, .sdio_o, .sdio_oe, .serial_data_out, .serial_data_out_oe, .scl_i(scl),
      .sda_i(sda_line), .sda_o, .sda_oe, .xfer_pin, .xfer_pin_en, .wr_valid, .wr_req, .rd_addr, .rd_data,
      .rd_from_active, .xfer_pulse, .i2c_mode);
   regmap_model u_map (.ref_clk, .wr_valid, .wr_req, .rd_addr, .rd_from_active, .xfer_pulse, .rd_data);

   // clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // log buffer writes and transfer pulses
   always @(posedge ref_clk) begin
      if (wr_valid === 1'b1) wq.push_back(wr_req);
      if (xfer_pulse === 1'b1) nx++;
   end

   task print_verdict;
      if (miscompares == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task do_reset(input logic p);
      @(posedge ref_clk) reset_n <= 1'b0;
      protocol_select_pin <= p;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      lsb = 1'b0;
      four_w = 1'b0;
   endtask

   // one spi frame: instruction then n bytes, 800 ns shift clock
   task automatic spi(input logic rw, input logic [14:0] a, input int n, input logic [7:0] d0, input logic [7:0] d1);
      logic [15:0] w;
      logic [15:0] d;
      int p;
      int pos;
      w = {rw, a};
      d = {d0, d1};
      @(posedge ref_clk) chip_select_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 16 + 8 * n; i++) begin
         p = i - 16;
         pos = lsb ? p % 8 : 7 - p % 8;
         @(posedge ref_clk) spi_clk <= 1'b0;
         sdio_h <= (i < 16) ? (lsb ? w[i] : w[15 - i]) : (rw ? ~sdio_h : d[8 - 8 * (p / 8) + pos]);
         repeat (4) @(posedge ref_clk);
         spi_clk <= 1'b1;
         repeat (3) @(posedge ref_clk);
         @(negedge ref_clk);
         if (rw && i >= 16) r16[8 - 8 * (p / 8) + pos] = four_w ? (serial_data_out_oe ? serial_data_out : 1'bx) :
            (sdio_oe ? sdio_o : 1'bx);
      end
      @(posedge ref_clk) spi_clk <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chip_select_n <= 1'b1;
      sdio_h <= ~sdio_h;
      repeat (8) @(posedge ref_clk);
   endtask

   task exp_wr(input logic [13:0] a, input logic [7:0] v);
      serial_control_port_pkg::wr_req_t t;
      t = wq.size() > 0 ? wq.pop_front() : 'x;
      `CHK(t, {a, v})
   endtask

   task pulse(input logic en);
      @(posedge ref_clk) xfer_pin_en <= en;
      xfer_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      xfer_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      xfer_pin_en <= 1'b0;
   endtask

   // i2c bit of 3*ih+1 clocks (ih 8: 400 khz, ih 33: 100 khz), value read while scl high
   task i2c_bit(input logic b, output logic r);
      @(posedge ref_clk) sda_h <= b;
      repeat (ih) @(posedge ref_clk);
      scl <= 1'b1;
      repeat (ih) @(posedge ref_clk);
      r = sda_line;
      scl <= 1'b0;
      repeat (ih) @(posedge ref_clk);
   endtask

   task i2c_byte(input logic [7:0] v, input logic m);
      logic r;
      for (int i = 7; i >= 0; i--) i2c_bit(v[i], got[i]);
      i2c_bit(m, r);
      ack = ~r;
   endtask

   task i2c_start;
      @(posedge ref_clk) sda_h <= 1'b1;
      repeat (8) @(posedge ref_clk);
      scl <= 1'b1;
      repeat (8) @(posedge ref_clk);
      sda_h <= 1'b0;
      repeat (8) @(posedge ref_clk);
      scl <= 1'b0;
   endtask

   task i2c_stop;
      @(posedge ref_clk) sda_h <= 1'b0;
      repeat (6) @(posedge ref_clk);
      scl <= 1'b1;
      repeat (8) @(posedge ref_clk);
      sda_h <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask

   // watchdog
   initial begin
      repeat (40000) @(posedge ref_clk);
      miscompares++;
      print_verdict;
   end

   // main sequence
   initial begin
      {reset_n, protocol_select_pin, spi_clk, sdio_h, xfer_pin, xfer_pin_en, i2c_addr_sel} = '0;
      {chip_select_n, scl, sda_h} = 3'b111;
      miscompares = 0;
      total_checks = 0;
      nx = 0;
      ih = 8;
      do_reset(1'b0);
      spi(1'b0, 15'h0000, 1, 8'h20, 8'h00);
      spi(1'b0, 15'h4010, 2, 8'ha5, 8'h5a);
      exp_wr(14'h0010, 8'ha5);
      exp_wr(14'h0011, 8'h5a);
      spi(1'b1, 15'h0010, 2, 8'h00, 8'h00);
      `CHK(r16, 16'ha55a)
      spi(1'b0, 15'h0001, 1, 8'h20, 8'h00);
      spi(1'b1, 15'h0010, 1, 8'h00, 8'h00);
      `CHK(r16[15:8], 8'h00)
      spi(1'b0, 15'h000f, 1, 8'h01, 8'h00);
      `CHK(nx, 1)
      spi(1'b1, 15'h0010, 1, 8'h00, 8'h00);
      `CHK(r16[15:8], 8'ha5)
      spi(1'b0, 15'h0010, 1, 8'h11, 8'h00);
      exp_wr(14'h0010, 8'h11);
      pulse(1'b0);
      `CHK(nx, 1)
      pulse(1'b1);
      `CHK(nx, 2)
      spi(1'b1, 15'h0010, 1, 8'h00, 8'h00);
      `CHK(r16[15:8], 8'h11)
      spi(1'b0, 15'h0000, 1, 8'h70, 8'h00);
      lsb = 1'b1;
      four_w = 1'b1;
      spi(1'b0, 15'h0030, 2, 8'h3c, 8'hc3);
      exp_wr(14'h0030, 8'h3c);
      exp_wr(14'h0031, 8'hc3);
      spi(1'b1, 15'h0010, 1, 8'h00, 8'h00);
      `CHK(r16[15:8], 8'h11)
      spi(1'b0, 15'h0000, 1, 8'h50, 8'h00);
      spi(1'b0, 15'h0031, 2, 8'h12, 8'h34);
      exp_wr(14'h0031, 8'h12);
      exp_wr(14'h0030, 8'h34);
      // second reset selects the i2c front end
      i2c_addr_sel <= 2'b01;
      do_reset(1'b1);
      `CHK(i2c_mode, 1'b1)
      ih = 33;
      i2c_start;
      i2c_byte(8'h92, 1'b1);
      `CHK(ack, 1'b1)
      i2c_byte(8'h00, 1'b1);
      i2c_byte(8'h20, 1'b1);
      i2c_byte(8'h77, 1'b1);
      `CHK(ack, 1'b1)
      i2c_stop;
      exp_wr(14'h0020, 8'h77);
      ih = 8;
      i2c_start;
      i2c_byte(8'h94, 1'b1);
      `CHK(ack, 1'b0)
      i2c_stop;
      i2c_start;
      i2c_byte(8'h92, 1'b1);
      i2c_byte(8'h00, 1'b1);
      i2c_byte(8'h11, 1'b1);
      i2c_start;
      i2c_byte(8'h93, 1'b1);
      `CHK(ack, 1'b1)
      i2c_byte(8'hff, 1'b0);
      `CHK(got, 8'h5a)
      i2c_byte(8'hff, 1'b1);
      `CHK(got, 8'h11)
      i2c_byte(8'hff, 1'b1);
      `CHK(got, 8'hff)
      i2c_stop;
      print_verdict;
   end
endmodule

`default_nettype wire
